// >>> cgsp_pkg.sv
// Package for the clock gear, standby and register protection block.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package cgsp_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CTRL0  = 8'hE0;
    localparam logic [7:0] IDX_CTRL1  = 8'hE1;
    localparam logic [7:0] IDX_CTRL2  = 8'hE2;
    localparam logic [7:0] IDX_NOISE0 = 8'hE3;
    localparam logic [7:0] IDX_KEY    = 8'hE4;

    // ==========================================================
    // Reset values and the key value that turns protection off
    localparam logic [7:0] RST_CTRL0  = 8'h80;
    localparam logic [7:0] RST_CTRL1  = 8'h04;
    localparam logic [7:0] RST_CTRL2  = 8'h2C;
    localparam logic [7:0] RST_NOISE0 = 8'h23;
    localparam logic [7:0] KEY_OPEN   = 8'h1F;

    // ==========================================================
    // Field positions
    localparam int CTRL0_PRCK_LO  = 0;
    localparam int CTRL1_GEAR_LO  = 0;
    localparam int CTRL1_SYSCK    = 3;
    localparam int CTRL2_HALTM_LO = 2;
    localparam int CTRL2_WUP_LO   = 4;
    localparam int N0_LOWDRV      = 0;
    localparam int N0_HIGHDRV     = 1;
    localparam int N0_EXTERNAL_CLOCK_INPUT_SELECT       = 2;
    localparam int N0_ADDRESS_LATCH_STROBE_ENABLE       = 3;
    localparam int N0_PROTECT     = 7;

    // ==========================================================
    // Encodings
    localparam logic [1:0] HALTM_CPU_ONLY_SLEEP = 2'h3;
    localparam logic [1:0] HALTM_OSCILLATOR_ONLY_SLEEP = 2'h2;
    localparam logic [1:0] HALTM_STOP  = 2'h1;
    localparam logic [1:0] PRCK_FPH    = 2'h0;
    localparam logic [2:0] GEAR_MAX    = 3'h4;
    localparam logic [5:0] FC64_LAST   = 6'h3F;

    // ==========================================================
    // Warm-up figures in oscillator cycles and the unit count
    localparam int WUP_SHORT = 256;
    localparam int WUP_MID   = 16384;
    localparam int WUP_LONG  = 65536;
    localparam int NUM_UNITS = 9;

    typedef enum logic [2:0] {
        ST_RUN   = 3'h0,
        ST_CPU_ONLY_SLEEP = 3'h1,
        ST_OSCILLATOR_ONLY_SLEEP = 3'h2,
        ST_STOP  = 3'h3,
        ST_WAKE  = 3'h4
    } cgsp_state_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } cgsp_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } cgsp_wb_rsp_s;

    typedef struct packed {
        logic       nmi;
        logic       req;
        logic [2:0] level;
        logic [2:0] mask;
        logic       deepWake;
        logic       maskedWake;
    } cgsp_irq_s;

    typedef struct packed {
        logic cpuRun;
        logic sysClockRun;
        logic oscRun;
        logic rtcRun;
        logic portHold;
        logic resumeService;
        logic resumeNext;
    } cgsp_power_s;

    typedef struct packed {
        logic highDriveNormal;
        logic lowDriveNormal;
        logic highDriverOn;
        logic oscPinForceHigh;
        logic aleOutputEnable;
        logic protectWriteAllow;
    } cgsp_pins_s;

endpackage : cgsp_pkg

// >>> cgsp_clock_gear_standby.sv
// Clock gear, prescaler input, noise reduction bits, write protection
// and standby controller of a small microcontroller.
// Assumes clk is the high-frequency oscillator clock and that every
// input is synchronous to it.
// Functional notes
// - New gear division takes effect only after the warm-up count ends.
// - Prescaler input is gear clock over 2 or fc/16 over 4.
// - High oscillator drive bit: 0 weakens drive, resets to 1.
// - Low oscillator drive bit: 0 weakens drive, resets to 1.
// - External clock bit 1 stops the driver, pin held at 1; resets 0.
// - Address strobe enable 0 floats the strobe pin; resets to 0.
// - Key other than 1FH turns protection on; guarded writes ignored.
// - Key 1FH turns protection off; state readable in noise register.
// - Key register stays writable while protection is on.
// - Halt enters cpu-only, oscillator-only or stop by mode 11/10/01.
// - Cpu-only sleep stops CPU; each unit runs if its enable is set.
// - Oscillator-only sleep stops system clock; oscillator and RTC run.
// - Stop halts every circuit including the oscillator.
// - Both sleeps hold ports and keep the interrupt controller running.
// - Request level not below mask releases cpu-only sleep, or the deeper halts with deepWake, and is serviced.
// - Masked request releases nothing unless its source is permitted.
// - Non-maskable interrupt releases cpu-only sleep, or the deeper halts with deepWake; always serviced.
// - Permitted masked release resumes after halt without servicing.
// - Reset releases all three halt states.
// - Gear resets to 100 on the high clock: system clock is fc/32.
`timescale 1ns/100ps

module cgsp_clock_gear_standby #(
    parameter int WUP_SHORT_CYC = cgsp_pkg::WUP_SHORT,
    parameter int WUP_MID_CYC   = cgsp_pkg::WUP_MID,
    parameter int WUP_LONG_CYC  = cgsp_pkg::WUP_LONG,
    parameter int UNITS         = cgsp_pkg::NUM_UNITS
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire cgsp_pkg::cgsp_wb_req_s wbReq,
    output      cgsp_pkg::cgsp_wb_rsp_s wbRsp,
    input  wire logic                 haltExec,
    input  wire logic                 lowOscTick,
    input  wire cgsp_pkg::cgsp_irq_s  irq,
    input  wire logic [UNITS-1:0]     idleEnable,
    output      cgsp_pkg::cgsp_power_s power,
    output      logic [UNITS-1:0]     unitRun,
    output      cgsp_pkg::cgsp_pins_s pins,
    output      logic                 systemTick,
    output      logic                 prescalerTick
);

    // ==========================================================
    // State
    typedef struct packed {
        cgsp_pkg::cgsp_wb_rsp_s rsp;
        logic [7:0]             ctrl0;
        logic [7:0]             ctrl1;
        logic [7:0]             ctrl2;
        logic [7:0]             noise0;
        logic                   protect;
        logic [2:0]             activeGear;
        logic                   gearPend;
        logic [16:0]            warmCnt;
        logic [5:0]             divCnt;
        logic                   fphPhase;
        cgsp_pkg::cgsp_state_e  mode;
        logic                   wakeService;
        cgsp_pkg::cgsp_power_s  power;
        logic [UNITS-1:0]       unitRun;
        cgsp_pkg::cgsp_pins_s   pins;
        logic                   sysTick;
        logic                   presTick;
    } cgsp_core_s;

    cgsp_core_s r;
    cgsp_core_s next_r;

    logic [UNITS-1:0] next_unitRun;

    // ==========================================================
    // Warm-up length from the select field
    function automatic logic [16:0] warmLen(input logic [1:0] sel);
        case (sel)
            2'h2:    warmLen = 17'(WUP_MID_CYC - 1);
            2'h3:    warmLen = 17'(WUP_LONG_CYC - 1);
            default: warmLen = 17'(WUP_SHORT_CYC - 1);
        endcase
    endfunction : warmLen

    // Gear clock tick mask: divide by 1, 2, 4, 8 or 16
    function automatic logic [5:0] gearMask(input logic [2:0] gear);
        case (gear)
            3'h0:    gearMask = 6'h00;
            3'h1:    gearMask = 6'h01;
            3'h2:    gearMask = 6'h03;
            3'h3:    gearMask = 6'h07;
            default: gearMask = 6'h0F;
        endcase
    endfunction : gearMask

    // ==========================================================
    // Per-unit run enables while only the cpu sleeps
    genvar gi;
    generate
        for (gi = 0; gi < UNITS; gi++) begin : g_unit
            assign next_unitRun[gi] = idleEnable[gi];
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb begin
        logic        access;
        logic        doWrite;
        logic [7:0]  idx;
        logic [7:0]  wd;
        logic        fphTick;
        logic        levelOk;
        logic        serviced;
        logic        resumed;
        logic [31:0] rd;
        logic        gearWrite;

        access   = 1'b0;
        doWrite  = 1'b0;
        idx      = 8'h00;
        wd       = 8'h00;
        fphTick  = 1'b0;
        levelOk  = 1'b0;
        serviced = 1'b0;
        resumed  = 1'b0;
        rd       = 32'h00000000;
        gearWrite = 1'b0;
        next_r   = r;

        // ======================================================
        // Bus slave: one-cycle acknowledge, dropped the cycle after
        access  = wbReq.cyc && wbReq.stb && !r.rsp.ack;
        idx     = wbReq.adr[9:2];
        wd      = wbReq.dat[7:0];
        doWrite = access && wbReq.we && wbReq.sel[0];
        next_r.rsp.ack = access;
        next_r.rsp.dat = 32'h00000000;

        case (idx)
            cgsp_pkg::IDX_CTRL0:  rd = {24'h000000, r.ctrl0};
            cgsp_pkg::IDX_CTRL1:  rd = {24'h000000, r.ctrl1};
            cgsp_pkg::IDX_CTRL2:  rd = {24'h000000, r.ctrl2};
            cgsp_pkg::IDX_NOISE0: begin
                rd = {24'h000000, r.noise0};
                rd[cgsp_pkg::N0_PROTECT] = r.protect;
            end
            default:              rd = 32'h00000000;
        endcase
        if (access && !wbReq.we) begin
            next_r.rsp.dat = rd;
        end

        if (doWrite) begin
            if (idx == cgsp_pkg::IDX_KEY) begin
                next_r.protect = (wd != cgsp_pkg::KEY_OPEN);
            end else if (!r.protect) begin
                case (idx)
                    cgsp_pkg::IDX_CTRL0: next_r.ctrl0 = wd;
                    cgsp_pkg::IDX_CTRL1: begin
                        next_r.ctrl1 = wd;
                        if (wd[cgsp_pkg::CTRL1_GEAR_LO +: 3] != r.activeGear) begin
                            next_r.gearPend = 1'b1;
                            gearWrite       = 1'b1;
                            next_r.warmCnt  =
                                warmLen(r.ctrl2[cgsp_pkg::CTRL2_WUP_LO +: 2]);
                        end
                    end
                    cgsp_pkg::IDX_CTRL2: next_r.ctrl2 = wd;
                    cgsp_pkg::IDX_NOISE0: begin
                        next_r.noise0 = {1'b0, 2'h1, 1'b0, wd[3:0]};
                    end
                    default: ;
                endcase
            end
        end

        // ======================================================
        // Gear change waits for the warm-up count
        if (r.gearPend && !gearWrite) begin
            if (r.warmCnt == 17'h00000) begin
                next_r.gearPend   = 1'b0;
                next_r.activeGear = (r.ctrl1[2:0] > cgsp_pkg::GEAR_MAX) ?
                    cgsp_pkg::GEAR_MAX : r.ctrl1[2:0];
            end else begin
                next_r.warmCnt = r.warmCnt - 17'h00001;
            end
        end

        // ======================================================
        // Clock division: gear clock then system clock at half of it
        next_r.divCnt = r.divCnt + 6'h01;
        if (r.ctrl1[cgsp_pkg::CTRL1_SYSCK]) begin
            fphTick = lowOscTick;
        end else begin
            fphTick = ((r.divCnt & gearMask(r.activeGear)) ==
                       gearMask(r.activeGear));
        end
        if (fphTick) begin
            next_r.fphPhase = !r.fphPhase;
        end
        next_r.sysTick = fphTick && r.fphPhase &&
                         (r.mode == cgsp_pkg::ST_RUN ||
                          r.mode == cgsp_pkg::ST_CPU_ONLY_SLEEP);
        if (r.ctrl0[cgsp_pkg::CTRL0_PRCK_LO +: 2] == cgsp_pkg::PRCK_FPH) begin
            next_r.presTick = fphTick && r.fphPhase;
        end else begin
            next_r.presTick = (r.divCnt == cgsp_pkg::FC64_LAST);
        end
        if (r.mode == cgsp_pkg::ST_STOP || r.mode == cgsp_pkg::ST_OSCILLATOR_ONLY_SLEEP) begin
            next_r.presTick = 1'b0;
        end

        // ======================================================
        // Standby controller
        levelOk = irq.req && (irq.level >= irq.mask);
        next_r.power.resumeService = 1'b0;
        next_r.power.resumeNext    = 1'b0;
        case (r.mode)
            cgsp_pkg::ST_RUN: begin
                if (haltExec) begin
                    case (r.ctrl2[cgsp_pkg::CTRL2_HALTM_LO +: 2])
                        cgsp_pkg::HALTM_CPU_ONLY_SLEEP: next_r.mode = cgsp_pkg::ST_CPU_ONLY_SLEEP;
                        cgsp_pkg::HALTM_OSCILLATOR_ONLY_SLEEP: next_r.mode = cgsp_pkg::ST_OSCILLATOR_ONLY_SLEEP;
                        cgsp_pkg::HALTM_STOP:  next_r.mode = cgsp_pkg::ST_STOP;
                        default:               next_r.mode = cgsp_pkg::ST_RUN;
                    endcase
                end
            end
            cgsp_pkg::ST_CPU_ONLY_SLEEP, cgsp_pkg::ST_OSCILLATOR_ONLY_SLEEP, cgsp_pkg::ST_STOP: begin
                if (r.mode == cgsp_pkg::ST_CPU_ONLY_SLEEP || irq.deepWake) begin
                    serviced = irq.nmi || levelOk;
                    resumed  = !serviced && irq.req && irq.maskedWake;
                end
                if (r.mode == cgsp_pkg::ST_STOP && (serviced || resumed)) begin
                    next_r.mode        = cgsp_pkg::ST_WAKE;
                    next_r.wakeService = serviced;
                    next_r.warmCnt     =
                        warmLen(r.ctrl2[cgsp_pkg::CTRL2_WUP_LO +: 2]);
                end else if (serviced || resumed) begin
                    next_r.mode                = cgsp_pkg::ST_RUN;
                    next_r.power.resumeService = serviced;
                    next_r.power.resumeNext    = resumed;
                end
            end
            cgsp_pkg::ST_WAKE: begin
                if (r.warmCnt == 17'h00000) begin
                    next_r.mode                = cgsp_pkg::ST_RUN;
                    next_r.power.resumeService = r.wakeService;
                    next_r.power.resumeNext    = !r.wakeService;
                end else begin
                    next_r.warmCnt = r.warmCnt - 17'h00001;
                end
            end
            default: next_r.mode = cgsp_pkg::ST_RUN;
        endcase

        // ======================================================
        // Registered outputs
        next_r.power.cpuRun      = (next_r.mode == cgsp_pkg::ST_RUN);
        next_r.power.sysClockRun = (next_r.mode == cgsp_pkg::ST_RUN) ||
                                   (next_r.mode == cgsp_pkg::ST_CPU_ONLY_SLEEP);
        next_r.power.oscRun      = (next_r.mode != cgsp_pkg::ST_STOP);
        next_r.power.rtcRun      = (next_r.mode != cgsp_pkg::ST_STOP);
        next_r.power.portHold    = (next_r.mode == cgsp_pkg::ST_CPU_ONLY_SLEEP) ||
                                   (next_r.mode == cgsp_pkg::ST_OSCILLATOR_ONLY_SLEEP);
        case (next_r.mode)
            cgsp_pkg::ST_RUN:   next_r.unitRun = '1;
            cgsp_pkg::ST_CPU_ONLY_SLEEP: next_r.unitRun = next_unitRun;
            default:            next_r.unitRun = '0;
        endcase

        next_r.pins.highDriveNormal   = next_r.noise0[cgsp_pkg::N0_HIGHDRV];
        next_r.pins.lowDriveNormal    = next_r.noise0[cgsp_pkg::N0_LOWDRV];
        next_r.pins.highDriverOn      = !next_r.noise0[cgsp_pkg::N0_EXTERNAL_CLOCK_INPUT_SELECT] &&
                                        (next_r.mode != cgsp_pkg::ST_STOP);
        next_r.pins.oscPinForceHigh   = next_r.noise0[cgsp_pkg::N0_EXTERNAL_CLOCK_INPUT_SELECT];
        next_r.pins.aleOutputEnable   = next_r.noise0[cgsp_pkg::N0_ADDRESS_LATCH_STROBE_ENABLE];
        next_r.pins.protectWriteAllow = !next_r.protect;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r                         <= '0;
            r.ctrl0                   <= cgsp_pkg::RST_CTRL0;
            r.ctrl1                   <= cgsp_pkg::RST_CTRL1;
            r.ctrl2                   <= cgsp_pkg::RST_CTRL2;
            r.noise0                  <= cgsp_pkg::RST_NOISE0;
            r.activeGear              <= cgsp_pkg::GEAR_MAX;
            r.mode                    <= cgsp_pkg::ST_RUN;
            r.power.cpuRun            <= 1'b1;
            r.power.sysClockRun       <= 1'b1;
            r.power.oscRun            <= 1'b1;
            r.power.rtcRun            <= 1'b1;
            r.unitRun                 <= '1;
            r.pins.highDriveNormal    <= 1'b1;
            r.pins.lowDriveNormal     <= 1'b1;
            r.pins.highDriverOn       <= 1'b1;
            r.pins.protectWriteAllow  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign wbRsp         = r.rsp;
    assign power         = r.power;
    assign unitRun       = r.unitRun;
    assign pins          = r.pins;
    assign systemTick    = r.sysTick;
    assign prescalerTick = r.presTick;

endmodule : cgsp_clock_gear_standby

// >>> cgsp_props.sv
// Checker for the clock gear, standby and protection block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module cgsp_props #(
    parameter int UNITS = 9
) (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire cgsp_pkg::cgsp_wb_req_s wbReq,
    input wire cgsp_pkg::cgsp_wb_rsp_s wbRsp,
    input wire cgsp_pkg::cgsp_irq_s    irq,
    input wire logic [UNITS-1:0]       idleEnable,
    input wire cgsp_pkg::cgsp_power_s  power,
    input wire logic [UNITS-1:0]       unitRun,
    input wire cgsp_pkg::cgsp_pins_s   pins
);
    // ====
    // Helpers and clocking
    wire cpu_only_sleep = !power.cpuRun && power.sysClockRun;
    wire lvlOk = irq.req && (irq.level >= irq.mask);
    // Marks the warm-up after stop, which is not oscillator-only sleep
    logic stopSeen;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stopSeen <= 1'b0;
        end else if (!power.oscRun) begin
            stopSeen <= 1'b1;
        end else if (power.cpuRun) begin
            stopSeen <= 1'b0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ====
    // Properties
    a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack
        |=> wbRsp.ack) else $error("request not answered next cycle");
    a_protect_flag: assert property (wbRsp.ack && !wbReq.we
        && wbReq.adr[9:2] == cgsp_pkg::IDX_NOISE0
        |-> wbRsp.dat[7] != pins.protectWriteAllow)
        else $error("protect flag disagrees with write allow");
    a_ext_pin: assert property (pins.oscPinForceHigh
        |-> !pins.highDriverOn) else $error("driver on with external clock");
    a_cpu_only_sleep_units: assert property (cpu_only_sleep
        |-> power.portHold && unitRun == idleEnable)
        else $error("cpu-only sleep unit run wrong");
    a_oscillator_only_sleep_clock: assert property (!stopSeen && !power.sysClockRun
        && power.oscRun |-> power.rtcRun && power.portHold && unitRun == '0)
        else $error("oscillator-only sleep outputs wrong");
    a_stop_all: assert property (!power.oscRun
        |-> !power.sysClockRun && !power.rtcRun && !pins.highDriverOn)
        else $error("stop left something running");
    a_wake_level: assert property (cpu_only_sleep && lvlOk
        |=> power.cpuRun && power.resumeService)
        else $error("unmasked request did not wake");
    a_wake_nmi: assert property (cpu_only_sleep && irq.nmi
        |=> power.cpuRun && power.resumeService)
        else $error("nmi did not wake");
    a_masked_stay: assert property (cpu_only_sleep && !irq.nmi
        && !irq.maskedWake && !lvlOk |=> !power.cpuRun)
        else $error("masked request woke the cpu");
    a_masked_next: assert property (cpu_only_sleep && !irq.nmi
        && irq.req && irq.maskedWake && !lvlOk
        |=> power.resumeNext && !power.resumeService)
        else $error("masked wake did not resume without service");
endmodule : cgsp_props

// >>> cgsp_clock_gear_standby_bench.sv
// Self-checking bench for the clock gear and standby block.
// Assumes short warm-up parameters; the checker is bound at the foot.
`timescale 1ns/100ps
module cgsp_clock_gear_standby_bench;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] exp;
    } cgsp_row_s;
    logic                   clk = 1'b0;
    logic                   reset_n = 1'b0;
    cgsp_pkg::cgsp_wb_req_s wbReq = '0;
    cgsp_pkg::cgsp_wb_rsp_s wbRsp;
    logic                   haltExec = 1'b0;
    logic                   lowOscTick = 1'b0;
    logic                   lowRun = 1'b0;
    cgsp_pkg::cgsp_irq_s    irq = '0;
    logic [8:0]             idleEnable = 9'h0A5;
    cgsp_pkg::cgsp_power_s  power;
    logic [8:0]             unitRun;
    cgsp_pkg::cgsp_pins_s   pins;
    logic                   systemTick;
    logic                   prescalerTick;
    logic [31:0]            rd;
    int                     errors = 0;
    int                     checksDone = 0;
    int                     p;
    cgsp_row_s              rows [6] = '{'{8'hE0, 8'h80}, '{8'hE1, 8'h04},
        '{8'hE2, 8'h2C}, '{8'hE3, 8'h23}, '{8'hE4, 8'h00}, '{8'h10, 8'h00}};
    // ====
    // Clock and design
    always #25 clk = ~clk;
    always @(posedge clk) lowOscTick <= lowRun && !lowOscTick;
    cgsp_clock_gear_standby #(.WUP_SHORT_CYC(4), .WUP_MID_CYC(8),
        .WUP_LONG_CYC(16), .UNITS(9)) DUT (.clk(clk), .reset_n(reset_n),
        .wbReq(wbReq), .wbRsp(wbRsp), .haltExec(haltExec),
        .lowOscTick(lowOscTick), .irq(irq), .idleEnable(idleEnable),
        .power(power), .unitRun(unitRun), .pins(pins),
        .systemTick(systemTick), .prescalerTick(prescalerTick));
    // ====
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick
    task automatic bus(input logic we, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {24'h0, d}};
        do begin
            @(posedge clk);
        end while (wbRsp.ack !== 1'b1);
        rd = wbRsp.dat;
        wbReq <= '0;
    endtask : bus
    task automatic period(input bit pre);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while ((pre ? prescalerTick : systemTick) !== 1'b1 && p < 200);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while ((pre ? prescalerTick : systemTick) !== 1'b1 && p < 200);
    endtask : period
    task automatic halt(input logic [1:0] m);
        bus(1'b1, cgsp_pkg::IDX_CTRL2, {4'h2, m, 2'b00});
        @(posedge clk);
        haltExec <= 1'b1;
        @(posedge clk);
        haltExec <= 1'b0;
        tick(1);
    endtask : halt
    task automatic test_done;
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // ====
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b0, rows[i].idx, 8'h00);
            chk(rd, {24'h0, rows[i].exp});
        end
        chk(pins.highDriveNormal, 1'b1);
        chk(pins.lowDriveNormal, 1'b1);
        chk(pins.oscPinForceHigh, 1'b0);
        chk(pins.aleOutputEnable, 1'b0);
        $display("test reset values done");
        bus(1'b1, cgsp_pkg::IDX_NOISE0, 8'h0C);
        bus(1'b0, cgsp_pkg::IDX_NOISE0, 8'h00);
        chk(rd, 32'h2C);
        chk(pins, 32'h07);
        bus(1'b1, cgsp_pkg::IDX_KEY, 8'h1E);
        bus(1'b1, cgsp_pkg::IDX_NOISE0, 8'h0B);
        bus(1'b1, cgsp_pkg::IDX_CTRL1, 8'h00);
        bus(1'b0, cgsp_pkg::IDX_NOISE0, 8'h00);
        chk(rd, 32'hAC);
        bus(1'b0, cgsp_pkg::IDX_CTRL1, 8'h00);
        chk(rd, 32'h04);
        chk(pins.protectWriteAllow, 1'b0);
        bus(1'b1, cgsp_pkg::IDX_KEY, 8'h1F);
        bus(1'b1, cgsp_pkg::IDX_NOISE0, 8'h0B);
        bus(1'b0, cgsp_pkg::IDX_NOISE0, 8'h00);
        chk(rd, 32'h2B);
        $display("test noise and protection done");
        period(1'b1);
        chk(p, 32);
        bus(1'b1, cgsp_pkg::IDX_CTRL0, 8'h81);
        tick(70);
        period(1'b1);
        chk(p, 64);
        bus(1'b1, cgsp_pkg::IDX_CTRL0, 8'h80);
        period(1'b0);
        chk(p, 32);
        bus(1'b1, cgsp_pkg::IDX_CTRL1, 8'h00);
        bus(1'b1, 8'h10, 8'h00);
        p = 0;
        repeat (4) begin
            @(posedge clk);
            if (systemTick === 1'b1) p++;
        end
        chk(p <= 1, 1'b1);
        tick(80);
        period(1'b0);
        chk(p, 2);
        bus(1'b1, cgsp_pkg::IDX_CTRL1, 8'h04);
        bus(1'b1, 8'h10, 8'h00);
        tick(80);
        bus(1'b1, cgsp_pkg::IDX_CTRL1, 8'h0C);
        lowRun <= 1'b1;
        period(1'b0);
        chk(p, 4);
        lowRun <= 1'b0;
        bus(1'b1, cgsp_pkg::IDX_CTRL1, 8'h04);
        $display("test clocks done");
        halt(2'b11);
        chk(power, 32'h3C);
        chk(unitRun, 32'h0A5);
        irq <= '{1'b0, 1'b1, 3'h2, 3'h5, 1'b0, 1'b0};
        tick(3);
        chk(power.cpuRun, 1'b0);
        irq.maskedWake <= 1'b1;
        tick(2);
        chk(power, 32'h79);
        irq <= '0;
        halt(2'b11);
        irq <= '{1'b0, 1'b1, 3'h5, 3'h5, 1'b0, 1'b0};
        tick(2);
        chk(power, 32'h7A);
        irq <= '0;
        halt(2'b11);
        irq.nmi <= 1'b1;
        tick(2);
        chk(power, 32'h7A);
        irq <= '0;
        halt(2'b10);
        chk(power, 32'h1C);
        irq <= '{1'b0, 1'b1, 3'h5, 3'h1, 1'b0, 1'b0};
        tick(3);
        chk(power.cpuRun, 1'b0);
        irq.deepWake <= 1'b1;
        tick(2);
        chk(power, 32'h7A);
        irq <= '0;
        halt(2'b01);
        chk(power, 32'h00);
        irq <= '{1'b1, 1'b0, 3'h0, 3'h0, 1'b1, 1'b0};
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (power.resumeService !== 1'b1 && p < 100);
        chk(p >= 8 && p < 100, 1'b1);
        irq <= '0;
        halt(2'b00);
        chk(power.cpuRun, 1'b1);
        halt(2'b01);
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
        chk(power, 32'h78);
        $display("test halt modes done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end
endmodule : cgsp_clock_gear_standby_bench

bind cgsp_clock_gear_standby cgsp_props #(.UNITS(UNITS)) u_props (
    .clk(clk), .reset_n(reset_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .irq(irq), .idleEnable(idleEnable), .power(power),
    .unitRun(unitRun), .pins(pins));
